/* verilog/emms_params.svh */
// named offsets, field positions, reset values and timing figures of the mode sequencer
// assumes inclusion by bare name from the design file
`ifndef EMMS_PARAMS_SVH
`define EMMS_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define EMMS_OFF_STATUS 8'h00
`define EMMS_OFF_MODE 8'h08
`define EMMS_OFF_VSEL 8'h09
`define EMMS_OFF_CHG 8'h10
`define EMMS_OFF_WARN 8'h11
`define EMMS_OFF_STOR 8'h12
`define EMMS_OFF_OPT 8'h13

// ****************************************************************
// field positions
// ****************************************************************
`define EMMS_ST_READY 0
`define EMMS_ST_EARLY_WARN 1
`define EMMS_ST_ALARM 2
`define EMMS_ST_LOWBAT 3
`define EMMS_MODE_ACT 2
`define EMMS_MODE_CONT 1
`define EMMS_MODE_OND 0
`define EMMS_CHG_HIZ 4
`define EMMS_WARN_EN 7

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define EMMS_RST_MODE 8'h00
`define EMMS_RST_VSEL 8'hF6
`define EMMS_RST_CHG 8'h60
`define EMMS_RST_WARN 8'h00
`define EMMS_RST_STOR 8'h00
`define EMMS_RST_OPT 8'h00
`define EMMS_MODE_STBY 3'h0
`define EMMS_MODE_CMRET 3'h2

// ****************************************************************
// timing
// ****************************************************************
`define EMMS_CLK_MHZ 200
`define EMMS_POR_MS 20
`define EMMS_POR_CYC (`EMMS_POR_MS * 1000 * `EMMS_CLK_MHZ)

`endif

/* verilog/emms_pkg.sv */
// types shared by the mode sequencer design
// assumes emms_params.svh is on the include path
package emms_pkg;
  typedef enum logic [2:0] {
    EMMS_STBY = 3'h0,
    EMMS_CHARGE = 3'h1,
    EMMS_READY = 3'h2,
    EMMS_ACTIVE = 3'h3,
    EMMS_CONT = 3'h4
  } emms_state_t;

  // host register request carried as one bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } emms_req_t;

  // analog-side condition inputs
  typedef struct packed {
    logic cap_full;
    logic cap_low;
    logic overload;
    logic bat_low;
  } emms_sense_t;
endpackage

/* verilog/emms_sequencer.sv */
// mode sequencer of the battery energy manager: register file and state machine
// assumes a decoded serial front end giving one-cycle register strobes, and analog sense levels
//
// Notes on behaviour
// RULE1: host waits 20 ms after power-on before any serial access; busy flag shown.
// RULE2: host may rewrite configuration registers charge_config to optimizer_config before a cycle.
// RULE3: host programs warning threshold and enable in register warning_config.
// RULE4: host selects load shape or fixed storage voltage via mode_control and voltage_select.
// RULE5: host writes output and fixed storage voltage settings into voltage_select.
// RULE6: on-demand bit in mode_control starts charge, then regulated output.
// RULE7: ready shown on pin and status bit 0; output then at set voltage.
// RULE8: status status_flags reports alarm, early warning and battery depleting.
// RULE9: early warning also shows on the ready pin.
// RULE10: on early warning host writes 000b to mode field for standby.
// RULE11: on alarm host removes load and writes 000b for standby.
// RULE12: battery depleting only advises; operation continues.
// RULE13: after normal pulse host writes 000b to return to standby.
// RULE14: continuous bit in mode_control keeps storage charged awaiting active request.
// RULE15: in continuous mode, after ready, bit 2 of mode_control enters active.
// RULE16: writing 010b after a continuous pulse returns to continuous mode.
// RULE17: output high impedance set keeps output disabled except in active.
// RULE18: charge current follows bits 7 to 5 of charge_config during charge.
// RULE19: output voltage setting is voltage_select bits 3 to 0, default 3.0 V.
// RULE20: host applies load only after ready seen high this cycle.
// RULE21: host preserves other mode_control bits with read-modify-write.
`timescale 1ns/1ps
`include "emms_params.svh"

module emms_sequencer #(
  parameter int POR_CYCLES = `EMMS_POR_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from the serial front end
  input wire emms_pkg::emms_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // analog sense levels
  input wire emms_pkg::emms_sense_t sense,
  // pins and converter controls
  output logic ready_pin,
  output logic por_busy,
  output logic charge_en,
  output logic [2:0] charge_current,
  output logic out_en,
  output logic out_hiz,
  output logic [3:0] out_vset,
  output logic [3:0] fix_vset
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] mode_q, vsel_q, chg_q, warn_q, stor_q, opt_q;
  logic [31:0] por_cnt_q;
  emms_pkg::emms_state_t state_q, state_d;
  logic early_warning_q, alarm_q, lowbat_q;
  logic [7:0] status;

  // register write strobe for one offset
  function automatic logic hit(input emms_pkg::emms_req_t r, input logic [7:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  // power-on wait; accesses during it are ignored so a hasty host cannot disturb defaults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      por_cnt_q <= 32'h0;
    end else if (por_cnt_q != POR_CYCLES[31:0]) begin
      por_cnt_q <= por_cnt_q + 32'h1; // RULE1
    end
  end
  assign por_busy = (por_cnt_q != POR_CYCLES[31:0]);

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vsel_q <= `EMMS_RST_VSEL;
      chg_q <= `EMMS_RST_CHG;
      warn_q <= `EMMS_RST_WARN;
      stor_q <= `EMMS_RST_STOR;
      opt_q <= `EMMS_RST_OPT;
    end else if (!por_busy) begin
      if (hit(req, `EMMS_OFF_VSEL)) vsel_q <= req.wdata; // RULE5
      if (hit(req, `EMMS_OFF_CHG)) chg_q <= req.wdata; // RULE2
      if (hit(req, `EMMS_OFF_WARN)) warn_q <= req.wdata; // RULE3
      if (hit(req, `EMMS_OFF_STOR)) stor_q <= req.wdata;
      if (hit(req, `EMMS_OFF_OPT)) opt_q <= req.wdata;
    end
  end

  // mode control register; bits above the mode field hold the load shape index
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= `EMMS_RST_MODE;
    end else if (!por_busy && hit(req, `EMMS_OFF_MODE)) begin
      mode_q <= req.wdata; // RULE4
    end
  end

  // ****************************************************************
  // state machine
  // ****************************************************************
  // standby wins whenever the mode field is cleared, regardless of state
  always_comb begin
    state_d = state_q;
    case (state_q)
      emms_pkg::EMMS_STBY: begin
        if (mode_q[`EMMS_MODE_OND] || mode_q[`EMMS_MODE_CONT]) begin
          state_d = emms_pkg::EMMS_CHARGE; // RULE6
        end
      end
      emms_pkg::EMMS_CHARGE: begin
        if (sense.cap_full) begin
          state_d = mode_q[`EMMS_MODE_OND] ? emms_pkg::EMMS_ACTIVE : emms_pkg::EMMS_CONT;
        end
      end
      emms_pkg::EMMS_CONT: begin
        if (mode_q[`EMMS_MODE_ACT]) begin
          state_d = emms_pkg::EMMS_ACTIVE; // RULE15
        end else if (sense.cap_low) begin
          state_d = emms_pkg::EMMS_CHARGE; // RULE14
        end
      end
      emms_pkg::EMMS_ACTIVE: begin
        if (mode_q[2:0] == `EMMS_MODE_CMRET) begin
          state_d = emms_pkg::EMMS_CONT; // RULE16
        end
      end
      default: state_d = emms_pkg::EMMS_STBY;
    endcase
    if (mode_q[2:0] == `EMMS_MODE_STBY) begin
      state_d = emms_pkg::EMMS_STBY;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= emms_pkg::EMMS_STBY;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // status flags: live levels; early warning and alarm only in active, low battery in any state
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      early_warning_q <= 1'b0;
      alarm_q <= 1'b0;
      lowbat_q <= 1'b0;
    end else begin
      early_warning_q <= warn_q[`EMMS_WARN_EN] && sense.cap_low
                         && (state_q == emms_pkg::EMMS_ACTIVE);
      alarm_q <= (state_q == emms_pkg::EMMS_ACTIVE) && (sense.overload || sense.cap_low); // RULE8
      lowbat_q <= sense.bat_low; // RULE12
    end
  end

  always_comb begin
    status = 8'h00;
    status[`EMMS_ST_READY] = ready_pin; // RULE7
    status[`EMMS_ST_EARLY_WARN] = early_warning_q;
    status[`EMMS_ST_ALARM] = alarm_q;
    status[`EMMS_ST_LOWBAT] = lowbat_q;
  end

  // read data from flip-flops, unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd && !por_busy;
      case (req.addr)
        `EMMS_OFF_STATUS: rdata <= status;
        `EMMS_OFF_MODE: rdata <= mode_q;
        `EMMS_OFF_VSEL: rdata <= vsel_q;
        `EMMS_OFF_CHG: rdata <= chg_q;
        `EMMS_OFF_WARN: rdata <= warn_q;
        `EMMS_OFF_STOR: rdata <= stor_q;
        `EMMS_OFF_OPT: rdata <= opt_q;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // pins and converter controls
  // ****************************************************************
  // ready pin drops on early warning so a gpio watcher sees it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_pin <= 1'b0;
      charge_en <= 1'b0;
      charge_current <= 3'h0;
      out_en <= 1'b0;
      out_hiz <= 1'b0;
      out_vset <= 4'h0;
      fix_vset <= 4'h0;
    end else begin
      ready_pin <= ((state_d == emms_pkg::EMMS_ACTIVE) || (state_d == emms_pkg::EMMS_CONT))
                   && !(warn_q[`EMMS_WARN_EN] && sense.cap_low); // RULE9
      charge_en <= (state_d == emms_pkg::EMMS_CHARGE);
      charge_current <= chg_q[7:5]; // RULE18
      out_en <= (state_d == emms_pkg::EMMS_ACTIVE);
      out_hiz <= chg_q[`EMMS_CHG_HIZ] && (state_d != emms_pkg::EMMS_ACTIVE); // RULE17
      out_vset <= vsel_q[3:0]; // RULE19
      fix_vset <= vsel_q[7:4];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_hiz_outside_active: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
    (!$past(sys_rst) && $past(chg_q[`EMMS_CHG_HIZ]) && state_q != emms_pkg::EMMS_ACTIVE)
    |-> out_hiz) else $error("output not high impedance outside active");
  chk_ond_start: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    (state_q == emms_pkg::EMMS_STBY && mode_q[2:0] == 3'h1) |=> state_q == emms_pkg::EMMS_CHARGE)
    else $error("on-demand did not start charge");
  chk_ready_status: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    (rvalid && $past(req.addr) == `EMMS_OFF_STATUS)
    |-> rdata[`EMMS_ST_READY] == $past(ready_pin))
    else $error("status ready differs from pin");
  chk_cont_active: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    (state_q == emms_pkg::EMMS_CONT && mode_q[2:0] == 3'h6) |=> state_q == emms_pkg::EMMS_ACTIVE)
    else $error("active request ignored in continuous");
  chk_cont_return: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    (state_q == emms_pkg::EMMS_ACTIVE && mode_q[2:0] == 3'h2) |=> state_q == emms_pkg::EMMS_CONT)
    else $error("no return to continuous");
  chk_standby_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    (mode_q[2:0] == 3'h0) |=> state_q == emms_pkg::EMMS_STBY ##1 !out_en)
    else $error("standby not entered");
  chk_ichg_follow: assert property (@(posedge clk) disable iff (sys_rst) // RULE18
    $changed(chg_q) |=> charge_current == $past(chg_q[7:5])) else $error("charge current stale");
  chk_vset_follow: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
    $changed(vsel_q) |=> out_vset == $past(vsel_q[3:0])) else $error("output setting stale");
  chk_ew_ready: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    (warn_q[`EMMS_WARN_EN] && sense.cap_low) |=> !ready_pin) else $error("ready high on warning");
  chk_por_block: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    (por_busy && req.wr) |=> $stable(mode_q)) else $error("write taken during power-on wait");
  chk_lowbat_adv: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    (state_q == emms_pkg::EMMS_ACTIVE && sense.bat_low && mode_q[2:0] == 3'h1
     && !sense.overload) |=> state_q == emms_pkg::EMMS_ACTIVE) else $error("low battery stopped cycle");
  chk_alarm_flag: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    (state_q == emms_pkg::EMMS_ACTIVE && sense.overload) |=> status[`EMMS_ST_ALARM])
    else $error("alarm not reported");

endmodule

/* dv/emms_host_model.sv */
// host model: issues register strobes to the sequencer
// assumes clk from the bench, por_busy and read data from the device
`timescale 1ns/1ps
module emms_host_model (
  // clock and power-on status
  input wire logic clk,
  input wire logic por_busy,
  // register access
  output emms_pkg::emms_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // idle bus from time zero
  initial req = '0;

  // no access at all while the power-on hold is up
  task automatic hold_por();
    while (por_busy !== 1'b0) @(posedge clk);
  endtask

  // one strobe, then back to idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hold_por();
    poke(a, d);
  endtask

  // strobe with no power-on wait, to show that early accesses are dropped
  task automatic poke(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask

  // read answer stands one cycle, taken just after it lands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    hold_por();
    @(posedge clk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask

  // mode change keeps the upper bits of the mode register
  task automatic set_mode(input logic [2:0] m);
    logic [7:0] v;
    rd(8'h08, v);
    wr(8'h08, {v[7:3], m});
  endtask
endmodule

/* dv/testbench.sv */
// self-checking bench of the mode sequencer with a host model
// assumes the design and host model are compiled first
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  emms_pkg::emms_req_t req;
  emms_pkg::emms_sense_t sense = '0;
  logic [7:0] rdata, rv;
  logic rvalid, ready_pin, por_busy, charge_en, out_en, out_hiz;
  logic [2:0] charge_current;
  logic [3:0] out_vset, fix_vset;
  logic [31:0] seed = 32'h1BBCF708;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // short power-on hold keeps the run brief
  emms_sequencer #(.POR_CYCLES(10)) u_dut (.clk(clk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .sense(sense), .ready_pin(ready_pin),
    .por_busy(por_busy), .charge_en(charge_en), .charge_current(charge_current),
    .out_en(out_en), .out_hiz(out_hiz), .out_vset(out_vset), .fix_vset(fix_vset));
  emms_host_model u_host (.clk(clk), .por_busy(por_busy), .req(req), .rdata(rdata),
    .rvalid(rvalid));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] st_exp(input logic r, e, a, l);
    return {4'h0, l, a, e, r};
  endfunction

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait on the ready pin
  task automatic wait_rdy(input logic v);
    for (int i = 0; i < 40 && ready_pin !== v; i++) settle(1);
  endtask

  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    settle(1);
    chk("por_busy", por_busy, 1'b1);
    u_host.rd(8'h08, rv);
    chk("mode", rv, 8'h00);
    u_host.rd(8'h09, rv);
    chk("vsel", rv, 8'hF6);
    u_host.rd(8'h10, rv);
    chk("chg", rv, 8'h60);
    u_host.rd(8'h05, rv);
    chk("unmapped", rv, 8'h00);
    chk("out_vset", out_vset, 4'h6);
    $display("test reset done");
    // random configuration, hiz bit kept clear
    repeat (4) begin
      seed = lfsr(seed);
      u_host.wr(8'h10, seed[7:0] & 8'hEF);
      u_host.wr(8'h09, seed[15:8]);
      settle(2);
      chk("cur", charge_current, seed[7:5]);
      chk("out_vset", out_vset, seed[11:8]);
      chk("fix_vset", fix_vset, seed[15:12]);
    end
    $display("test config done");
    // on-demand cycle with hiz and warning enabled
    u_host.wr(8'h10, 8'h70);
    u_host.wr(8'h11, 8'h80);
    u_host.set_mode(3'h1);
    settle(3);
    chk("charge_en", charge_en, 1'b1);
    chk("hiz", out_hiz, 1'b1);
    @(posedge clk) sense.cap_full <= 1'b1;
    wait_rdy(1'b1);
    chk("ready", ready_pin, 1'b1);
    chk("out_en", out_en, 1'b1);
    chk("hiz", out_hiz, 1'b0);
    u_host.rd(8'h00, rv);
    chk("status", rv, st_exp(1'b1, 1'b0, 1'b0, 1'b0));
    @(posedge clk) sense.bat_low <= 1'b1;
    settle(2);
    u_host.rd(8'h00, rv);
    chk("status", rv, st_exp(1'b1, 1'b0, 1'b0, 1'b1));
    chk("out_en", out_en, 1'b1);
    @(posedge clk) sense.cap_low <= 1'b1;
    wait_rdy(1'b0);
    chk("ready", ready_pin, 1'b0);
    u_host.rd(8'h00, rv);
    chk("status", rv & 8'h0E, st_exp(1'b0, 1'b1, 1'b1, 1'b1) & 8'h0E);
    u_host.set_mode(3'h0);
    settle(2);
    chk("out_en", out_en, 1'b0);
    chk("hiz", out_hiz, 1'b1);
    $display("test on-demand done");
    // overload alarm in active
    @(posedge clk) sense <= '0;
    u_host.set_mode(3'h1);
    @(posedge clk) sense.cap_full <= 1'b1;
    wait_rdy(1'b1);
    @(posedge clk) sense.overload <= 1'b1;
    settle(2);
    u_host.rd(8'h00, rv);
    chk("status", rv & 8'h0E, st_exp(1'b0, 1'b0, 1'b1, 1'b0));
    u_host.set_mode(3'h0);
    settle(2);
    chk("out_en", out_en, 1'b0);
    $display("test alarm done");
    // continuous mode, active request, return to continuous
    @(posedge clk) sense <= '0;
    u_host.set_mode(3'h2);
    settle(2);
    chk("charge_en", charge_en, 1'b1);
    @(posedge clk) sense.cap_full <= 1'b1;
    wait_rdy(1'b1);
    chk("out_en", out_en, 1'b0);
    u_host.set_mode(3'h6);
    settle(2);
    chk("out_en", out_en, 1'b1);
    u_host.set_mode(3'h2);
    settle(2);
    chk("out_en", out_en, 1'b0);
    chk("ready", ready_pin, 1'b1);
    u_host.set_mode(3'h0);
    settle(2);
    chk("ready", ready_pin, 1'b0);
    $display("test continuous done");
    // random sense levels and unmapped offsets in standby: only low battery shows
    repeat (4) begin
      seed = lfsr(seed);
      @(posedge clk) sense <= seed[3:0];
      settle(2);
      u_host.rd(8'h00, rv);
      chk("status", rv, st_exp(1'b0, 1'b0, 1'b0, seed[0]));
      chk("charge_en", charge_en, 1'b0);
      u_host.rd({3'h1, seed[12:8]}, rv);
      chk("unmapped", rv, 8'h00);
    end
    $display("test random sense done");
    // mid-run reset: defaults return and a hasty write is dropped
    @(posedge clk) sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    settle(1);
    chk("por_busy", por_busy, 1'b1);
    u_host.poke(8'h08, 8'h01);
    u_host.rd(8'h08, rv);
    chk("mode", rv, 8'h00);
    chk("charge_en", charge_en, 1'b0);
    u_host.rd(8'h11, rv);
    chk("warn", rv, 8'h00);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
